// *** vbc_video_ctrl.sv ***
// video board control: timing controller, video RAM address mux, port decode, control port
// assumes host bus signals are synchronous to ref_clk; keyboard and clock events are pins
`timescale 1ns/1ps
`include "vbc_defs.svh"

module vbc_video_ctrl #(
    parameter int ADDR_W = 16,
    parameter int VRAM_AW = 11
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic controller_reset_n,
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic hostRd,
    input wire logic hostWr,
    input wire logic memory_cycle,
    input wire logic io_cycle,
    input wire logic register_select,
    input wire logic select_qualifier,
    input wire logic processor_granted,
    input wire logic [7:0] keyData,
    input wire logic keyReady,
    input wire logic rtcTick,
    output logic [7:0] hostRdData,
    output logic hostRdValid,
    output logic waitReq_n,
    output logic video_memory_select,
    output logic mux_processor_select,
    output logic [VRAM_AW-1:0] vramAddr,
    output logic horizontal_sync,
    output logic vertical_sync,
    output logic displayEnable,
    output logic [13:0] refresh_address,
    output logic [4:0] raster_row_address,
    output logic character_clock,
    output logic blankVideo,
    output logic narrowMode,
    output logic [3:0] bankSelect,
    output logic bankRamEnable,
    output logic keyIrq_n,
    output logic nmiReq_n
);

    // controller reset, keyboard ready and clock pins are synchronised before use; resetn and keyData are read as they stand
    logic [1:0] ctlRstSync_q, keyRdySync_q, rtcSync_q;
    logic rtcPrev_q;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctlRstSync_q <= 2'h0;
            keyRdySync_q <= 2'h0;
            rtcSync_q <= 2'h0;
            rtcPrev_q <= 1'b0;
        end else begin
            ctlRstSync_q <= {ctlRstSync_q[0], controller_reset_n};
            keyRdySync_q <= {keyRdySync_q[0], keyReady};
            rtcSync_q <= {rtcSync_q[0], rtcTick};
            rtcPrev_q <= rtcSync_q[1];
        end
    end
    logic ctlRun;
    assign ctlRun = ctlRstSync_q[1];

    // port decode on the low address byte only
    logic [7:0] port;
    logic ioRd, ioWr;
    assign port = hostAddr[7:0];
    assign ioRd = io_cycle && hostRd;
    assign ioWr = io_cycle && hostWr;

    function automatic logic portHit(input logic [7:0] p, input logic [7:0] want);
        portHit = (p == want);
    endfunction

    // control port
    logic [7:0] ctrl_q;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_q <= `VBC_CTRL_RESET;
        end else if (ioWr && portHit(port, `VBC_PORT_CTRL)) begin
            ctrl_q <= hostWrData;
        end
    end

    // timing controller register file, untouched by controller reset
    logic [4:0] index_q;
    logic [7:0] regs_q [`VBC_NREG];
    logic idxWr, datWr;
    assign idxWr = ioWr && portHit(port, `VBC_PORT_KEYIDX);
    // write when hostWr high; index by its own port, data by the data port with register select high
    assign datWr = ioWr && portHit(port, `VBC_PORT_TDATA) && register_select;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            index_q <= 5'h00;
        end else if (idxWr) begin
            index_q <= hostWrData[4:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int i = 0; i < `VBC_NREG; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (datWr && (index_q < 5'(`VBC_NREG))) begin
            regs_q[index_q] <= hostWrData;
        end
    end

    // interrupt flags: set wins over clear
    logic keyIrq_q, rtcIrq_q;
    logic kbRd, clkClrRd, ctrlRd, tdRd;
    assign kbRd = ioRd && portHit(port, `VBC_PORT_KEYIDX);
    assign clkClrRd = ioRd && portHit(port, `VBC_PORT_CLKCLR);
    assign ctrlRd = ioRd && portHit(port, `VBC_PORT_CTRL);
    assign tdRd = ioRd && portHit(port, `VBC_PORT_TDATA) && register_select;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            keyIrq_q <= 1'b0;
        end else if (keyRdySync_q[1]) begin
            keyIrq_q <= 1'b1;
        end else if (kbRd) begin
            keyIrq_q <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rtcIrq_q <= 1'b0;
        end else if (rtcSync_q[1] && !rtcPrev_q) begin
            rtcIrq_q <= 1'b1;
        end else if (clkClrRd) begin
            rtcIrq_q <= 1'b0;
        end
    end

    // host read data
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hostRdData <= 8'h00;
            hostRdValid <= 1'b0;
        end else begin
            hostRdValid <= kbRd || tdRd || clkClrRd || ctrlRd;
            if (kbRd) begin
                hostRdData <= keyData;
            end else if (tdRd) begin
                hostRdData <= (index_q < 5'(`VBC_NREG)) ? regs_q[index_q] : 8'h00;
            end else if (ctrlRd) begin
                hostRdData <= {keyIrq_q, ctrl_q[6:4], 4'h0};
            end else begin
                hostRdData <= 8'h00;
            end
        end
    end

    // video RAM select, mux select and wait
    logic vsel, muxSel;
    assign vsel = (hostAddr[15:11] == `VBC_VRAM_TOP) && memory_cycle
        && ctrl_q[`VBC_BIT_VIDEN];
    assign muxSel = vsel && select_qualifier;
    vbc_pkg::vbc_grant_e grant_q;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            grant_q <= vbc_pkg::VBC_IDLE;
        end else begin
            unique case (grant_q)
                vbc_pkg::VBC_IDLE: begin
                    if (vsel) begin
                        grant_q <= vbc_pkg::VBC_WAITING;
                    end
                end
                vbc_pkg::VBC_WAITING: begin
                    if (!vsel) begin
                        grant_q <= vbc_pkg::VBC_IDLE;
                    end else if (processor_granted) begin
                        grant_q <= vbc_pkg::VBC_GRANTED;
                    end
                end
                vbc_pkg::VBC_GRANTED: begin
                    if (!vsel) begin
                        grant_q <= vbc_pkg::VBC_IDLE;
                    end
                end
                default: grant_q <= vbc_pkg::VBC_IDLE;
            endcase
        end
    end
    logic [VRAM_AW-1:0] ctlAddr;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            video_memory_select <= 1'b0;
            mux_processor_select <= 1'b0;
            waitReq_n <= 1'b1;
            vramAddr <= '0;
            bankRamEnable <= 1'b1;
        end else begin
            video_memory_select <= vsel;
            mux_processor_select <= muxSel;
            waitReq_n <= !(vsel && !processor_granted && grant_q != vbc_pkg::VBC_GRANTED);
            vramAddr <= muxSel ? hostAddr[VRAM_AW-1:0] : ctlAddr;
            bankRamEnable <= !ctrl_q[`VBC_BIT_VIDEN];
        end
    end

    // character clock enable from a divider; rate follows line width
    logic [7:0] divCnt_q;
    logic cclkEn;
    logic [7:0] divLimit;
    assign divLimit = ctrl_q[`VBC_BIT_NARROW] ? 8'(`VBC_DIV_NARROW - 1)
        : 8'(`VBC_DIV_WIDE - 1);
    assign cclkEn = (divCnt_q >= divLimit);
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            divCnt_q <= 8'h00;
            character_clock <= 1'b0;
        end else begin
            divCnt_q <= cclkEn ? 8'h00 : divCnt_q + 8'h01;
            // falling edge of the output marks the active transition
            if (cclkEn) begin
                character_clock <= 1'b0;
            end else if (divCnt_q == {1'b0, divLimit[7:1]}) begin
                character_clock <= 1'b1;
            end
        end
    end

    // raster timing counters
    logic [7:0] hCnt_q;
    logic [6:0] rowCnt_q;
    logic [4:0] rasCnt_q;
    logic [13:0] ma_q, lineStart_q;
    logic hEnd, rowEnd, frameEnd;
    logic [13:0] startAddr;
    assign startAddr = {regs_q[`VBC_R_STARTH][5:0], regs_q[`VBC_R_STARTL]};
    assign hEnd = (hCnt_q == regs_q[`VBC_R_HTOTAL]);
    assign rowEnd = (rasCnt_q == regs_q[`VBC_R_MAXRAS][4:0]);
    assign frameEnd = rowEnd && (rowCnt_q == regs_q[`VBC_R_VTOTAL][6:0]);
    always_ff @(posedge ref_clk) begin
        if (!resetn || !ctlRun) begin
            hCnt_q <= 8'h00;
            rasCnt_q <= 5'h00;
            rowCnt_q <= 7'h00;
            ma_q <= 14'h0000;
            lineStart_q <= 14'h0000;
        end else if (cclkEn) begin
            if (!hEnd) begin
                hCnt_q <= hCnt_q + 8'h01;
                ma_q <= ma_q + 14'h0001;
            end else begin
                hCnt_q <= 8'h00;
                if (frameEnd) begin
                    rasCnt_q <= 5'h00;
                    rowCnt_q <= 7'h00;
                    ma_q <= startAddr;
                    lineStart_q <= startAddr;
                end else if (rowEnd) begin
                    rasCnt_q <= 5'h00;
                    rowCnt_q <= rowCnt_q + 7'h01;
                    ma_q <= lineStart_q + 14'(regs_q[`VBC_R_HDISP]);
                    lineStart_q <= lineStart_q + 14'(regs_q[`VBC_R_HDISP]);
                end else begin
                    rasCnt_q <= rasCnt_q + 5'h01;
                    ma_q <= lineStart_q;
                end
            end
        end
    end
    assign ctlAddr = ma_q[VRAM_AW-1:0];

    logic hVis, vVis, hSyncOn, vSyncOn;
    assign hVis = hCnt_q < regs_q[`VBC_R_HDISP];
    assign vVis = rowCnt_q < regs_q[`VBC_R_VDISP][6:0];
    assign hSyncOn = (hCnt_q >= regs_q[`VBC_R_HSPOS])
        && (hCnt_q < regs_q[`VBC_R_HSPOS] + {4'h0, regs_q[`VBC_R_SYNCW][3:0]});
    assign vSyncOn = (rowCnt_q == regs_q[`VBC_R_VSPOS][6:0]);
    always_ff @(posedge ref_clk) begin
        if (!resetn || !ctlRun) begin
            horizontal_sync <= 1'b0;
            vertical_sync <= 1'b0;
            displayEnable <= 1'b0;
            refresh_address <= 14'h0000;
            raster_row_address <= 5'h00;
        end else if (cclkEn) begin
            horizontal_sync <= hSyncOn;
            vertical_sync <= vSyncOn;
            displayEnable <= hVis && vVis;
            refresh_address <= ma_q;
            raster_row_address <= rasCnt_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            blankVideo <= 1'b1;
            narrowMode <= 1'b0;
            bankSelect <= 4'h0;
            keyIrq_n <= 1'b1;
            nmiReq_n <= 1'b1;
        end else begin
            blankVideo <= ctrl_q[`VBC_BIT_BLANK];
            narrowMode <= ctrl_q[`VBC_BIT_NARROW];
            bankSelect <= ctrl_q[3:0];
            keyIrq_n <= !keyIrq_q;
            nmiReq_n <= !(rtcIrq_q && ctrl_q[`VBC_BIT_RTCEN]);
        end
    end

    property p_mux_select;
        @(posedge ref_clk) disable iff (!resetn)
        mux_processor_select |-> $past(vsel) && $past(select_qualifier);
    endproperty
    a_mux_select: assert property (p_mux_select) else $error("mux select without cause");
    property p_wait;
        @(posedge ref_clk) disable iff (!resetn)
        (vsel && !processor_granted && grant_q == vbc_pkg::VBC_IDLE) |=> !waitReq_n;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not asserted");
    property p_vsel;
        @(posedge ref_clk) disable iff (!resetn)
        video_memory_select |-> $past(hostAddr[15:11]) == 5'h1f && $past(memory_cycle);
    endproperty
    a_vsel: assert property (p_vsel) else $error("video select outside top 2K");
    property p_nmi;
        @(posedge ref_clk) disable iff (!resetn)
        !nmiReq_n |-> $past(ctrl_q[5]);
    endproperty
    a_nmi: assert property (p_nmi) else $error("clock interrupt while masked");
    property p_rtc_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (clkClrRd && !(rtcSync_q[1] && !rtcPrev_q)) |=> !rtcIrq_q;
    endproperty
    a_rtc_clear: assert property (p_rtc_clear) else $error("clock interrupt not cleared");
    property p_key_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (kbRd && !keyRdySync_q[1]) |=> !keyIrq_q ##1 keyIrq_n;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key interrupt not cleared");
    property p_stop;
        @(posedge ref_clk) disable iff (!resetn)
        !ctlRun |=> !horizontal_sync && !vertical_sync && !displayEnable && refresh_address == 0;
    endproperty
    a_stop: assert property (p_stop) else $error("outputs not low in controller reset");
    property p_ma_step;
        @(posedge ref_clk) disable iff (!resetn || !ctlRun)
        (cclkEn && !hEnd) |=> ma_q == $past(ma_q) + 14'h0001;
    endproperty
    a_ma_step: assert property (p_ma_step) else $error("refresh address did not step");
    property p_ctrl_wr;
        @(posedge ref_clk) disable iff (!resetn)
        (ioWr && port == 8'hff) |=> ##1 bankSelect == $past(hostWrData[3:0], 2);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("bank select not loaded");

    c_grant: cover property (@(posedge ref_clk) grant_q == vbc_pkg::VBC_GRANTED);
    c_key: cover property (@(posedge ref_clk) kbRd && keyIrq_q);
    c_vsync: cover property (@(posedge ref_clk) vertical_sync);
    c_narrow: cover property (@(posedge ref_clk) narrowMode && cclkEn);

endmodule // vbc_video_ctrl

// *** vbc_defs.svh ***
// constants for the video board control logic: port numbers, control bits, timing counts
// assumes a 100 MHz ref_clk and an 8-bit host I/O port space
`ifndef VBC_DEFS_SVH
`define VBC_DEFS_SVH
`define VBC_PORT_KEYIDX 8'hfc
`define VBC_PORT_TDATA 8'hfd
`define VBC_PORT_CLKCLR 8'hfe
`define VBC_PORT_CTRL 8'hff
`define VBC_VRAM_TOP 5'h1f
`define VBC_BIT_VIDEN 7
`define VBC_BIT_BLANK 6
`define VBC_BIT_RTCEN 5
`define VBC_BIT_NARROW 4
`define VBC_CTRL_RESET 8'h40
`define VBC_REF_CLK_MHZ 100
`define VBC_CHARACTER_CLOCK_WIDE_KHZ 1560
`define VBC_CHARACTER_CLOCK_NARROW_KHZ 780
`define VBC_DIV_WIDE ((`VBC_REF_CLK_MHZ * 1000) / `VBC_CHARACTER_CLOCK_WIDE_KHZ)
`define VBC_DIV_NARROW ((`VBC_REF_CLK_MHZ * 1000) / `VBC_CHARACTER_CLOCK_NARROW_KHZ)
`define VBC_NREG 18
`define VBC_R_HTOTAL 0
`define VBC_R_HDISP 1
`define VBC_R_HSPOS 2
`define VBC_R_SYNCW 3
`define VBC_R_VTOTAL 4
`define VBC_R_VDISP 6
`define VBC_R_VSPOS 7
`define VBC_R_MAXRAS 9
`define VBC_R_STARTH 12
`define VBC_R_STARTL 13
`endif

// *** vbc_pkg.sv ***
// types shared by the video board control logic
package vbc_pkg;
    typedef enum logic [1:0] {
        VBC_IDLE = 2'b00,
        VBC_WAITING = 2'b01,
        VBC_GRANTED = 2'b10
    } vbc_grant_e;
endpackage

// *** vbc_host_model.sv ***
// host processor model: drives memory and I/O cycles toward the video control block
// assumes a free-running ref_clk; every request changes at its falling edge
`timescale 1ns/1ps

module vbc_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] hostRdData,
    input wire logic hostRdValid,
    output logic [15:0] hostAddr,
    output logic [7:0] hostWrData,
    output logic hostRd,
    output logic hostWr,
    output logic memory_cycle,
    output logic io_cycle,
    output logic register_select,
    output logic select_qualifier,
    output logic processor_granted
);
    initial begin
        {hostAddr, hostWrData, hostRd, hostWr, memory_cycle, io_cycle} = '0;
        {register_select, select_qualifier, processor_granted} = '0;
    end
    // released address and data show the inverse of their last value, never a stale copy; strobes go low
    task automatic idle();
        {io_cycle, memory_cycle, hostRd, hostWr, processor_granted} = '0;
        hostAddr = ~hostAddr;
        hostWrData = ~hostWrData;
    endtask
    task automatic ioStart(input logic [7:0] a, input logic rd, input logic [7:0] d);
        @(negedge ref_clk);
        hostAddr = {8'($urandom), a};
        register_select = a[0];
        hostRd = rd;
        hostWr = !rd;
        hostWrData = d;
        io_cycle = 1'b1;
    endtask
    task automatic ioWr(input logic [7:0] a, input logic [7:0] d);
        ioStart(a, 1'b0, d);
        @(negedge ref_clk);
        idle();
    endtask
    task automatic ioRd(input logic [7:0] a, output logic [7:0] d);
        int n;
        ioStart(a, 1'b1, 8'h00);
        d = 8'hxx;
        n = 0;
        @(negedge ref_clk);
        idle();
        while (hostRdValid !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        if (hostRdValid === 1'b1) d = hostRdData;
    endtask
    // grant follows dly falling edges after the request; the host always wins the RAM
    task automatic memAcc(input logic [15:0] a, input logic q, input int dly);
        @(negedge ref_clk);
        hostAddr = a;
        select_qualifier = q;
        memory_cycle = 1'b1;
        repeat (dly) @(negedge ref_clk);
        processor_granted = 1'b1;
        repeat (3) @(negedge ref_clk);
        idle();
        select_qualifier = 1'b0;
    endtask
endmodule // vbc_host_model

// *** vbc_testbench.sv ***
// self-checking bench for the video board control block
// assumes vbc_host_model on the host bus; the bench drives the pins and checks outputs
`timescale 1ns/1ps
`include "vbc_defs.svh"

module testbench;
    logic ref_clk, resetn, controller_reset_n, keyReady, rtcTick;
    logic [7:0] keyData, hostRdData, hostWrData, rd, ctrl;
    logic [15:0] hostAddr, a;
    logic hostRd, hostWr, memory_cycle, io_cycle, register_select, select_qualifier;
    logic processor_granted, hostRdValid, waitReq_n, video_memory_select, mux_processor_select;
    logic [10:0] vramAddr;
    logic horizontal_sync, vertical_sync, displayEnable, character_clock;
    logic blankVideo, narrowMode, bankRamEnable, keyIrq_n, nmiReq_n, lastDe, q, v;
    logic [13:0] refresh_address, lastMa;
    logic [4:0] raster_row_address, lastRa;
    logic [3:0] bankSelect;
    logic [7:0] regVal [10] = '{15, 8, 10, 2, 3, 0, 2, 2, 0, 1};
    int n_errors = 0, n_checks = 0, cyc = 0, nSteps = 0, nHs = 0, nVs = 0;

    vbc_video_ctrl u_dut (.*);
    vbc_host_model u_host (.*);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic vselExp(input logic [15:0] a, input logic [7:0] c);
        return a[15:11] == `VBC_VRAM_TOP && c[`VBC_BIT_VIDEN];
    endfunction
    function automatic logic [7:0] statusExp(input logic k, input logic [7:0] c);
        return {k, c[6:4], 4'h0};
    endfunction
    task automatic tick(input logic key);
        keyReady = key;
        rtcTick = 1'b1;
        repeat (3) @(negedge ref_clk);
        keyReady = 1'b0;
        rtcTick = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // sampled mid character so the counters have settled
    always @(posedge character_clock) begin
        if (lastDe === 1'b1 && displayEnable === 1'b1) begin
            check("refresh step", refresh_address, lastMa + 14'h1);
            check("row within line", raster_row_address, lastRa);
            nSteps++;
        end
        lastMa = refresh_address;
        lastRa = raster_row_address;
        lastDe = displayEnable;
    end
    always @(posedge horizontal_sync) nHs++;
    always @(posedge vertical_sync) nVs++;

    initial begin
        void'($urandom(32'h9d06156e));
        {resetn, controller_reset_n, keyReady, rtcTick, lastDe} = '0;
        keyData = 8'h00;
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        check("wait idle", waitReq_n, 1'b1);
        check("blank at reset", blankVideo, 1'b1);
        check("bank ram at reset", bankRamEnable, 1'b1);
        check("nmi at reset", nmiReq_n, 1'b1);
        check("mux at reset", mux_processor_select, 1'b0);
        for (int i = 0; i < 12; i++) begin
            ctrl = (i < 3) ? 8'(24'hb0ff00 >> (8 * i)) : 8'($urandom);
            u_host.ioWr(`VBC_PORT_CTRL, ctrl);
            // a write to the clear port must leave the controls alone
            u_host.ioWr(`VBC_PORT_CLKCLR, ~ctrl);
            repeat (2) @(negedge ref_clk);
            check("bank select", bankSelect, ctrl[3:0]);
            check("narrow", narrowMode, ctrl[`VBC_BIT_NARROW]);
            check("blank", blankVideo, ctrl[`VBC_BIT_BLANK]);
            check("bank ram", bankRamEnable, !ctrl[`VBC_BIT_VIDEN]);
            u_host.ioRd(`VBC_PORT_CTRL, rd);
            check("status", rd, statusExp(1'b0, ctrl));
            a = i[0] ? {`VBC_VRAM_TOP, 11'($urandom)} : 16'($urandom);
            q = 1'($urandom);
            v = vselExp(a, ctrl);
            fork
                u_host.memAcc(a, q, 4);
                begin
                    repeat (3) @(negedge ref_clk);
                    check("video select", video_memory_select, v);
                    check("mux select", mux_processor_select, v & q);
                    check("wait", waitReq_n, !v);
                    if (v & q) check("vram addr", vramAddr, a[10:0]);
                    repeat (4) @(negedge ref_clk);
                    check("wait release", waitReq_n, 1'b1);
                end
            join
        end
        u_host.ioWr(`VBC_PORT_CTRL, 8'h80);
        tick(1'b0);
        check("masked clock irq", nmiReq_n, 1'b1);
        u_host.ioRd(`VBC_PORT_CLKCLR, rd);
        u_host.ioWr(`VBC_PORT_CTRL, 8'ha0);
        keyData = 8'($urandom);
        tick(1'b1);
        check("key irq", keyIrq_n, 1'b0);
        check("clock irq", nmiReq_n, 1'b0);
        u_host.ioRd(`VBC_PORT_CTRL, rd);
        check("status key", rd, statusExp(1'b1, 8'ha0));
        u_host.ioRd(`VBC_PORT_KEYIDX, rd);
        check("key data", rd, keyData);
        u_host.ioRd(`VBC_PORT_CLKCLR, rd);
        repeat (2) @(negedge ref_clk);
        check("key irq clear", keyIrq_n, 1'b1);
        check("clock irq clear", nmiReq_n, 1'b1);
        for (int i = 0; i < 10; i++) begin
            u_host.ioWr(`VBC_PORT_KEYIDX, 8'(i));
            u_host.ioWr(`VBC_PORT_TDATA, regVal[i]);
        end
        u_host.ioWr(`VBC_PORT_KEYIDX, 8'(`VBC_R_HDISP));
        u_host.ioRd(`VBC_PORT_TDATA, rd);
        check("data reg", rd, regVal[`VBC_R_HDISP]);
        controller_reset_n = 1'b1;
        repeat (20000) @(negedge ref_clk);
        check("display seen", nSteps > 0, 1'b1);
        check("hsync seen", nHs > 0, 1'b1);
        check("vsync seen", nVs > 0, 1'b1);
        controller_reset_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        check("timing held", {horizontal_sync, vertical_sync, displayEnable,
            refresh_address, raster_row_address}, 32'h0);
        u_host.ioRd(`VBC_PORT_TDATA, rd);
        check("data reg kept", rd, regVal[`VBC_R_HDISP]);
        tally_and_finish();
    end
endmodule // testbench
